// *** verilog/scq_pkg.sv ***
// package: register map, field positions and reset values of the transceiver control bank
package scq_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int NUM_QUADS      = 2;
    localparam int CH_PER_QUAD    = 4;
    localparam int NUM_CH         = NUM_QUADS * CH_PER_QUAD;
    localparam int ALARM_W        = 2;   // transmit and receive alarm per channel

    // ------------------------------------------------------------------
    // register indices (printed offsets; byte address is index times four)
    // ------------------------------------------------------------------
    localparam logic [19:0] IDX_QA_CH0   = 20'h30004;
    localparam logic [19:0] IDX_QA_CH1   = 20'h30014;
    localparam logic [19:0] IDX_QA_CH2   = 20'h30024;
    localparam logic [19:0] IDX_QA_CH3   = 20'h30034;
    localparam logic [19:0] IDX_QA_GLB   = 20'h30005;
    localparam logic [19:0] IDX_QA_SEL   = 20'h30006;
    localparam logic [19:0] IDX_QB_CH0   = 20'h30104;
    localparam logic [19:0] IDX_QB_CH1   = 20'h30114;
    localparam logic [19:0] IDX_QB_CH2   = 20'h30124;
    localparam logic [19:0] IDX_QB_CH3   = 20'h30134;
    localparam logic [19:0] IDX_QB_GLB   = 20'h30105;
    localparam logic [19:0] IDX_QB_SEL   = 20'h30106;
    // own addition: individual alarm masks, one byte per channel
    localparam logic [19:0] IDX_ALM_MASK = 20'h30200;
    // own addition: live alarm status (read only)
    localparam logic [19:0] IDX_ALM_STAT = 20'h30201;
    localparam int          ADDR_W       = 22;

    // ------------------------------------------------------------------
    // channel register fields
    // ------------------------------------------------------------------
    localparam int CH_ALARM_BLOCK_BIT = 1;
    localparam int CH_SOFT_RESET_BIT  = 2;
    localparam int CH_DIAG_EN_BIT     = 7;
    localparam logic [7:0] CH_IMPL_MASK  = 8'h86;
    localparam logic [7:0] CH_RESET_VAL  = 8'h02;

    // ------------------------------------------------------------------
    // quad global register fields
    // ------------------------------------------------------------------
    localparam int QD_ALARM_BLOCK_BIT = 1;
    localparam int QD_SOFT_RESET_BIT  = 2;
    localparam int QD_PWRDN_TX_BIT    = 3;
    localparam int QD_PWRDN_RX_BIT    = 4;
    localparam int QD_DIAG_EN_BIT     = 7;
    localparam logic [7:0] QD_IMPL_MASK  = 8'hBE;
    localparam logic [7:0] QD_RESET_VAL  = 8'h22;

    // ------------------------------------------------------------------
    // quad diagnostic select register
    // ------------------------------------------------------------------
    localparam int          SEL_W        = 5;
    localparam logic [7:0]  SEL_IMPL_MASK = 8'h1F;
    localparam logic [7:0]  SEL_RESET_VAL = 8'h00;

    // individual alarm mask byte: bit 0 transmit, bit 1 receive
    localparam logic [7:0]  AM_IMPL_MASK  = 8'h03;
    localparam logic [7:0]  AM_RESET_VAL  = 8'h03;

endpackage : scq_pkg

// *** verilog/scq_ctrl_regs.sv ***
// module: control register bank of an eight-channel, two-quad serial transceiver
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module scq_ctrl_regs
    import scq_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [NUM_CH*ALARM_W-1:0] alarm_raw,
    output logic      [NUM_CH-1:0]        chan_alarm_irq,
    output logic      [NUM_CH-1:0]        chan_logic_reset,
    output logic      [NUM_CH-1:0]        chan_diag_mode,
    output logic      [NUM_QUADS*SEL_W-1:0] quad_diag_select,
    output logic      [NUM_QUADS-1:0]     quad_pwrdn_tx,
    output logic      [NUM_QUADS-1:0]     quad_pwrdn_rx
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] ch_q   [NUM_CH];
    logic [7:0] ch_d   [NUM_CH];
    logic [7:0] qd_q   [NUM_QUADS];
    logic [7:0] qd_d   [NUM_QUADS];
    logic [7:0] sel_q  [NUM_QUADS];
    logic [7:0] sel_d  [NUM_QUADS];
    logic [7:0] am_q   [NUM_CH];
    logic [7:0] am_d   [NUM_CH];

    logic [31:0] prdata_q,  prdata_d;
    logic        pready_q,  pready_d;
    logic        pslverr_q, pslverr_d;

    logic [NUM_CH-1:0]          irq_q,   irq_d;
    logic [NUM_CH-1:0]          rst_q,   rst_d;
    logic [NUM_CH-1:0]          diag_q,  diag_d;
    logic [NUM_QUADS*SEL_W-1:0] dsel_q,  dsel_d;
    logic [NUM_QUADS-1:0]       ptx_q,   ptx_d;
    logic [NUM_QUADS-1:0]       prx_q,   prx_d;
    logic [NUM_CH*ALARM_W-1:0]  alm_s1_q, alm_s2_q;

    logic [19:0] idx;
    logic        addr_ok;
    logic        setup;
    logic [7:0]  rd_byte;
    logic        wr_lane0;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // indices are word numbers; the two low byte address bits are ignored
    assign idx      = paddr[ADDR_W-1:2];
    assign setup    = psel && !penable;
    assign wr_lane0 = pstrb[0];

    function automatic int ch_slot(input logic [19:0] a);
        case (a)
            IDX_QA_CH0: ch_slot = 0;
            IDX_QA_CH1: ch_slot = 1;
            IDX_QA_CH2: ch_slot = 2;
            IDX_QA_CH3: ch_slot = 3;
            IDX_QB_CH0: ch_slot = 4;
            IDX_QB_CH1: ch_slot = 5;
            IDX_QB_CH2: ch_slot = 6;
            IDX_QB_CH3: ch_slot = 7;
            default:    ch_slot = -1;
        endcase
    endfunction

    always_comb begin
        rd_byte = 8'h00;
        addr_ok = 1'b1;
        if (ch_slot(idx) >= 0) begin
            rd_byte = ch_q[ch_slot(idx)];
        end else begin
            case (idx)
                IDX_QA_GLB: rd_byte = qd_q[0];
                IDX_QB_GLB: rd_byte = qd_q[1];
                IDX_QA_SEL: rd_byte = sel_q[0];
                IDX_QB_SEL: rd_byte = sel_q[1];
                IDX_ALM_STAT: rd_byte = alm_s2_q[7:0];
                default: begin
                    if (idx >= IDX_ALM_MASK + 20'h00010 &&
                        idx <  IDX_ALM_MASK + 20'h00018) begin
                        rd_byte = am_q[idx[2:0]];
                    end else begin
                        addr_ok = 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // bus slave and register writes
    // ------------------------------------------------------------------
    // no wait state: the access completes on the first penable edge
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            ch_d[c] = ch_q[c];
            am_d[c] = am_q[c];
        end
        for (int q = 0; q < NUM_QUADS; q++) begin
            qd_d[q]  = qd_q[q];
            sel_d[q] = sel_q[q];
        end
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (setup) begin
            pready_d  = 1'b1;
            pslverr_d = !addr_ok;
            prdata_d  = (!pwrite && addr_ok) ? {24'h000000, rd_byte} : 32'h00000000;
        end
        if (psel && penable && pready_q && pwrite && addr_ok && wr_lane0) begin
            if (ch_slot(idx) >= 0) begin
                ch_d[ch_slot(idx)] = pwdata[7:0] & CH_IMPL_MASK;
            end else begin
                case (idx)
                    IDX_QA_GLB: qd_d[0]  = (pwdata[7:0] & QD_IMPL_MASK) | 8'h20;
                    IDX_QB_GLB: qd_d[1]  = (pwdata[7:0] & QD_IMPL_MASK) | 8'h20;
                    IDX_QA_SEL: sel_d[0] = pwdata[7:0] & SEL_IMPL_MASK;
                    IDX_QB_SEL: sel_d[1] = pwdata[7:0] & SEL_IMPL_MASK;
                    default: begin
                        if (idx >= IDX_ALM_MASK + 20'h00010 &&
                            idx <  IDX_ALM_MASK + 20'h00018) begin
                            am_d[idx[2:0]] = pwdata[7:0] & AM_IMPL_MASK;
                        end
                    end
                endcase
            end
        end
    end

    // quad alarm block comes up set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                ch_q[c] <= CH_RESET_VAL;
                am_q[c] <= AM_RESET_VAL;
            end
            for (int q = 0; q < NUM_QUADS; q++) begin
                qd_q[q]  <= QD_RESET_VAL;
                sel_q[q] <= SEL_RESET_VAL;
            end
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                ch_q[c] <= ch_d[c];
                am_q[c] <= am_d[c];
            end
            for (int q = 0; q < NUM_QUADS; q++) begin
                qd_q[q]  <= qd_d[q];
                sel_q[q] <= sel_d[q];
            end
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------------
    // alarm input synchroniser
    // ------------------------------------------------------------------
    // alarms come from the serial channel clocks, so two flops first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alm_s1_q <= '0;
            alm_s2_q <= '0;
        end else begin
            alm_s1_q <= alarm_raw;
            alm_s2_q <= alm_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // channel control outputs
    // ------------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            irq_d[c] = !qd_q[c / CH_PER_QUAD][QD_ALARM_BLOCK_BIT] &&
                       !ch_q[c][CH_ALARM_BLOCK_BIT] &&
                       |(alm_s2_q[c*ALARM_W +: ALARM_W] & ~am_q[c][ALARM_W-1:0]);
            rst_d[c] = qd_q[c / CH_PER_QUAD][QD_SOFT_RESET_BIT] ||
                       ch_q[c][CH_SOFT_RESET_BIT];
            diag_d[c] = qd_q[c / CH_PER_QUAD][QD_DIAG_EN_BIT] ||
                        ch_q[c][CH_DIAG_EN_BIT];
        end
        for (int q = 0; q < NUM_QUADS; q++) begin
            dsel_d[q*SEL_W +: SEL_W] = sel_q[q][SEL_W-1:0];
            ptx_d[q] = qd_q[q][QD_PWRDN_TX_BIT];
            prx_d[q] = qd_q[q][QD_PWRDN_RX_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q  <= '0;
            rst_q  <= '0;
            diag_q <= '0;
            dsel_q <= '0;
            ptx_q  <= '0;
            prx_q  <= '0;
        end else begin
            irq_q  <= irq_d;
            rst_q  <= rst_d;
            diag_q <= diag_d;
            dsel_q <= dsel_d;
            ptx_q  <= ptx_d;
            prx_q  <= prx_d;
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign chan_alarm_irq   = irq_q;
    assign chan_logic_reset = rst_q;
    assign chan_diag_mode   = diag_q;
    assign quad_diag_select = dsel_q;
    assign quad_pwrdn_tx    = ptx_q;
    assign quad_pwrdn_rx    = prx_q;

endmodule // scq_ctrl_regs

// *** bench/scq_ctrl_regs_asserts.sv ***
// checker: port-level properties of the transceiver control bank
`timescale 1ns/10ps
module scq_ctrl_regs_chk
    import scq_pkg::*;
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [ADDR_W-1:0]          paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic [NUM_CH*ALARM_W-1:0]  alarm_raw,
    input wire logic [NUM_CH-1:0]          chan_alarm_irq,
    input wire logic [NUM_CH-1:0]          chan_logic_reset,
    input wire logic [NUM_CH-1:0]          chan_diag_mode,
    input wire logic [NUM_QUADS*SEL_W-1:0] quad_diag_select,
    input wire logic [NUM_QUADS-1:0]       quad_pwrdn_tx,
    input wire logic [NUM_QUADS-1:0]       quad_pwrdn_rx
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [NUM_CH-1:0] ch_any;
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            ch_any[c] = |alarm_raw[2*c +: 2];
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    sequence s_setup; psel && !penable; endsequence
    sequence s_wr_a0;
        psel && penable && pready && pwrite && pstrb[0] && !pslverr && paddr == {IDX_QA_CH0, 2'b00};
    endsequence
    property p_setup_answer; s_setup |=> pready; endproperty
    property p_ready_access; pready |-> psel && penable ##1 !pready; endproperty
    property p_slverr; pslverr |-> pready; endproperty
    property p_rd_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    property p_unmapped_rd; pslverr && !pwrite |-> prdata == 32'h0; endproperty
    property p_reset_out;
        $rose(presetn) |-> chan_logic_reset == '0 && chan_diag_mode == '0 && chan_alarm_irq == '0;
    endproperty
    // an alarm that was never present cannot interrupt
    property p_irq_cause; (chan_alarm_irq & ~$past(ch_any, 3)) == '0; endproperty
    property p_diag_a0; s_wr_a0 ##0 pwdata[7] |-> ##2 chan_diag_mode[0]; endproperty
    property p_rst_a0; s_wr_a0 ##0 pwdata[2] |-> ##2 chan_logic_reset[0]; endproperty
    a_setup_answer: assert property (p_setup_answer) else $error("no answer after setup");
    a_ready_access: assert property (p_ready_access) else $error("pready out of access");
    a_slverr: assert property (p_slverr) else $error("pslverr without pready");
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
    a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without alarm");
    a_diag_a0: assert property (p_diag_a0) else $error("diag mode not set");
    a_rst_a0: assert property (p_rst_a0) else $error("soft reset not set");
endmodule // scq_ctrl_regs_chk

bind scq_ctrl_regs scq_ctrl_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_raw(alarm_raw),
    .chan_alarm_irq(chan_alarm_irq), .chan_logic_reset(chan_logic_reset),
    .chan_diag_mode(chan_diag_mode), .quad_diag_select(quad_diag_select),
    .quad_pwrdn_tx(quad_pwrdn_tx), .quad_pwrdn_rx(quad_pwrdn_rx));

// *** bench/testbench.sv ***
// testbench: directed scenarios for the transceiver control bank
`timescale 1ns/10ps
module testbench
    import scq_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [NUM_CH*ALARM_W-1:0] alarm_raw = '0;
    logic [NUM_CH-1:0] irq, lrst, diag;
    logic [NUM_QUADS*SEL_W-1:0] sel;
    logic [1:0] ptx, prx;
    int errors = 0, checked = 0;
    localparam logic [19:0] CHI [8] = '{IDX_QA_CH0, IDX_QA_CH1, IDX_QA_CH2, IDX_QA_CH3,
                                       IDX_QB_CH0, IDX_QB_CH1, IDX_QB_CH2, IDX_QB_CH3};
    always #25 pclk = ~pclk;
    // pstrb tied: byte-lane masking is not exercised
    scq_ctrl_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alarm_raw(alarm_raw), .chan_alarm_irq(irq),
        .chan_logic_reset(lrst), .chan_diag_mode(diag), .quad_diag_select(sel),
        .quad_pwrdn_tx(ptx), .quad_pwrdn_rx(prx));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [19:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready timeout", 0, 1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [19:0] idx, input logic [7:0] d); apb(1'b1, idx, d); endtask
    task automatic rdc(input string nm, input logic [19:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(nm, rd, exp);
    endtask
    // derived outputs follow a write one edge after it lands
    task automatic settle(); repeat (2) @(posedge pclk); endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_vals();
        for (int i = 0; i < 8; i++) rdc("chan reset", CHI[i], 32'h02);
        rdc("quad a reset", IDX_QA_GLB, 32'h22);
        rdc("quad b reset", IDX_QB_GLB, 32'h22);
        rdc("sel reset", IDX_QB_SEL, 32'h00);
        chk("diag reset", diag, 8'h00);
        chk("soft reset idle", lrst, 8'h00);
    endtask
    task automatic t_readback();
        for (int i = 0; i < 8; i++) wr(CHI[i], 8'hFE);
        settle();
        chk("diag all", diag, 8'hFF);
        chk("soft reset all", lrst, 8'hFF);
        for (int i = 0; i < 8; i++) rdc("chan readback", CHI[i], 32'h86);
        for (int i = 0; i < 8; i++) wr(CHI[i], 8'h00);
        settle();
        chk("soft reset released", lrst, 8'h00);
        chk("diag per channel off", diag, 8'h00);
    endtask
    task automatic t_quad_force();
        wr(IDX_QA_GLB, 8'h84);
        wr(IDX_QB_CH1, 8'h80);
        settle();
        chk("quad diag force", diag, 8'h2F);
        chk("quad soft reset", lrst, 8'h0F);
        rdc("config kept", IDX_QA_CH2, 32'h00);
        wr(IDX_QA_GLB, 8'h02);
        wr(IDX_QB_CH1, 8'h00);
        wr(IDX_QB_GLB, 8'h18);
        wr(IDX_QA_SEL, 8'hFF);
        wr(IDX_QB_SEL, 8'h0A);
        settle();
        rdc("sel readback", IDX_QA_SEL, 32'h1F);
        chk("sel out", sel, 10'h15F);
        chk("pwrdn tx", ptx, 2'b10);
        chk("pwrdn rx", prx, 2'b10);
        rdc("quad b readback", IDX_QB_GLB, 32'h38);
    endtask
    task automatic t_alarm();
        for (int c = 0; c < 8; c++) wr(IDX_ALM_MASK + 20'h10 + 20'(c), 8'h00);
        wr(IDX_ALM_MASK, 8'h00);
        wr(IDX_QA_GLB, 8'h00);
        wr(IDX_QB_GLB, 8'h00);
        alarm_raw <= '1;
        repeat (6) @(posedge pclk);
        chk("irq open", irq, 8'hFF);
        wr(IDX_QA_GLB, 8'h02);
        wr(IDX_QB_CH2, 8'h02);
        repeat (3) @(posedge pclk);
        chk("irq blocked", irq, 8'hB0);
        wr(IDX_ALM_MASK + 20'h14, 8'h01);
        repeat (3) @(posedge pclk);
        chk("irq one source masked", irq, 8'hB0);
        wr(IDX_ALM_MASK + 20'h14, 8'h03);
        repeat (3) @(posedge pclk);
        chk("irq both masked", irq, 8'hA0);
        rdc("alarm status", IDX_ALM_STAT, 32'hFF);
        alarm_raw <= '0;
    endtask
    task automatic t_unmapped();
        apb(1'b0, 20'h30007, 8'h00);
        chk("unmapped err", er, 1);
        chk("unmapped data", rd, 0);
    endtask
    task automatic final_report();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_readback();
        t_quad_force();
        t_alarm();
        t_unmapped();
        final_report();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        final_report();
    end
endmodule // testbench
